// >>> logic/lsod_core.sv
// How it works
// [RULE1] Gate and strobe levels are sampled every rising clock edge as 0 or 1.
// [RULE2] Pairs 10,00,10,11,10 on five edges switch into error detection.
// [RULE3] Serial data keeps shifting in while a mode pattern is clocked.
// [RULE4] In detection mode a gate fall starts a detection pass.
// [RULE5] A channel whose current is far too low records status 0.
// [RULE6] Controller sends no serial data during a detection pass.
// [RULE7] Controller holds gate low three edges, last one 2 us after fall.
// [RULE8] The last low-sampled edge of the pass stores channel status.
// [RULE9] Controller raises gate again before reading the status.
// [RULE10] After gate rises, status leaves on serial_out one bit per clock.
// [RULE11] Pairs 10,00,10,10,10 on five edges return to normal mode.
// [RULE12] Status flags are loaded into the display shift register.
// [RULE13] Status holds one bit per channel; healthy channels read 1.
// [RULE14] A broken pattern leaves the mode alone and restarts matching.
`timescale 1ns/10ps
module lsod_core import lsod_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Controller lines
	input wire logic serial_in,
	input wire logic latch_strobe,
	input wire logic output_gate,
	output logic serial_out,
	// Current comparator, 1 when channel current is near target
	input wire logic [7:0] channel_ok,
	// Sink stage
	output logic [7:0] sink_channel,
	output logic detect_mode,
	output logic latch_ready
);
	typedef struct packed {
		lsod_state_t state;
		logic [LSOD_HIST_W-1:0] hist;
		logic [1:0] low_cnt;
		logic gate_prev;
		logic [7:0] shift;
		logic [7:0] status;
		logic [7:0] latch;
		logic [7:0] sink;
		logic detect;
	} lsod_core_st_t;

	lsod_core_st_t s_q;
	lsod_core_st_t s_d;
	logic [1:0] pair;
	logic [LSOD_HIST_W-1:0] hist_now;
	logic entry_hit;
	logic resume_hit;
	logic fifo_push;
	logic fifo_ready;
	logic fifo_valid;
	logic [7:0] fifo_data;

	// Pattern window over the last five sampled pairs
	assign pair = {output_gate, latch_strobe}; // RULE1
	assign hist_now = {s_q.hist[LSOD_HIST_W-3:0], pair};
	assign entry_hit = (hist_now == LSOD_ENTRY_SEQ); // RULE2
	assign resume_hit = (hist_now == LSOD_RESUME_SEQ); // RULE11
	// Strobe samples queue the shift word only in normal mode
	assign fifo_push = latch_strobe && (s_q.state == LSOD_ST_NORMAL);

	// Latched words wait here until the outputs are blanked
	lsod_fifo #(.WIDTH(LSOD_CH), .DEPTH(LSOD_FIFO_DEPTH)) lsod_fifo_inst (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_valid(fifo_push),
		.in_ready(fifo_ready),
		.in_data(s_q.shift),
		.out_valid(fifo_valid),
		.out_ready(output_gate),
		.out_data(fifo_data)
	);

	// Next-state logic
	always_comb begin
		s_d = s_q;
		s_d.gate_prev = output_gate;
		s_d.hist = hist_now; // RULE1
		// Shift path runs by default, also while a pattern arrives
		s_d.shift = {s_q.shift[LSOD_CH-2:0], serial_in}; // RULE3
		if (fifo_valid && output_gate) begin
			s_d.latch = fifo_data;
		end
		case (s_q.state)
			LSOD_ST_NORMAL: begin
				// Only a complete entry pattern leaves normal mode
			end
			LSOD_ST_DET_IDLE: begin
				if (s_q.gate_prev && !output_gate) begin
					s_d.state = LSOD_ST_DET_PASS; // RULE4
					s_d.low_cnt = LSOD_LOW_ONE;
					// Fall edge still shifts: the resume pattern carries data too
				end
			end
			LSOD_ST_DET_PASS: begin
				if (!output_gate) begin
					// No serial data is taken during the pass
					s_d.shift = s_q.shift; // RULE6
					if (s_q.low_cnt != LSOD_LOW_MIN) begin
						s_d.low_cnt = s_q.low_cnt + 1'b1;
					end
					// Every low edge from the third on rewrites, so the last one stays
					if (s_d.low_cnt == LSOD_LOW_MIN) begin
						s_d.status = channel_ok; // RULE5 RULE8
					end
				end else begin
					s_d.state = LSOD_ST_DET_IDLE;
					s_d.low_cnt = LSOD_LOW_NONE;
					if (s_q.low_cnt == LSOD_LOW_MIN) begin
						s_d.shift = s_q.status; // RULE12 RULE9
					end
				end
			end
			default: begin
				s_d.state = LSOD_ST_NORMAL;
			end
		endcase
		// Complete patterns switch mode; anything else leaves it alone
		if (entry_hit) begin
			s_d.state = LSOD_ST_DET_IDLE; // RULE2
			s_d.low_cnt = LSOD_LOW_NONE;
			s_d.hist = LSOD_HIST_CLEAR; // RULE14
		end else if (resume_hit) begin
			s_d.state = LSOD_ST_NORMAL; // RULE11
			s_d.low_cnt = LSOD_LOW_NONE;
			s_d.hist = LSOD_HIST_CLEAR; // RULE14
		end
		// Sinks follow the latch while the active-low gate is low
		s_d.sink = output_gate ? LSOD_BYTE_ZERO : s_d.latch;
		// Mode flag taken from the next state so the output is a flop
		s_d.detect = (s_d.state != LSOD_ST_NORMAL);
	end

	// State register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s_q.state <= LSOD_ST_NORMAL;
			s_q.hist <= LSOD_HIST_CLEAR;
			s_q.low_cnt <= LSOD_LOW_NONE;
			s_q.gate_prev <= 1'b1;
			s_q.shift <= LSOD_BYTE_ZERO;
			s_q.status <= LSOD_STATUS_RST; // RULE13
			s_q.latch <= LSOD_BYTE_ZERO;
			s_q.sink <= LSOD_BYTE_ZERO;
			s_q.detect <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign serial_out = s_q.shift[LSOD_CH-1]; // RULE10
	assign sink_channel = s_q.sink;
	assign detect_mode = s_q.detect;
	assign latch_ready = fifo_ready;

	// Checks
	AST_SAMPLE: assert property (@(posedge clk_sys) disable iff (reset) // RULE1
		!entry_hit && !resume_hit |=> s_q.hist[1:0] == $past(pair))
		else $error("sampled pair not recorded");
	AST_ENTRY: assert property (@(posedge clk_sys) disable iff (reset) // RULE2
		entry_hit |=> s_q.state == LSOD_ST_DET_IDLE && detect_mode)
		else $error("entry pattern did not enter detection");
	AST_SHIFT_IN: assert property (@(posedge clk_sys) disable iff (reset) // RULE3
		s_q.state == LSOD_ST_NORMAL |=> s_q.shift[0] == $past(serial_in) && s_q.shift[7:1] == $past(s_q.shift[6:0]))
		else $error("serial data not shifted in normal mode");
	AST_PASS_START: assert property (@(posedge clk_sys) disable iff (reset) // RULE4
		s_q.state == LSOD_ST_DET_IDLE && s_q.gate_prev && !output_gate && !entry_hit && !resume_hit
		|=> s_q.state == LSOD_ST_DET_PASS && s_q.low_cnt == LSOD_LOW_ONE)
		else $error("gate fall did not start a pass");
	AST_STATUS_STORE: assert property (@(posedge clk_sys) disable iff (reset) // RULE8
		s_q.state == LSOD_ST_DET_IDLE && s_q.gate_prev && !output_gate ##1 !output_gate [*2]
		|=> s_q.status == $past(channel_ok))
		else $error("status not stored on third low edge");
	AST_LOAD_OUT: assert property (@(posedge clk_sys) disable iff (reset) // RULE12
		s_q.state == LSOD_ST_DET_PASS && output_gate && s_q.low_cnt == LSOD_LOW_MIN && !entry_hit && !resume_hit
		|=> s_q.shift == $past(s_q.status) ##1 serial_out == $past(s_q.status[6], 2))
		else $error("status not loaded into shift path");
	AST_HOLD_PASS: assert property (@(posedge clk_sys) disable iff (reset) // RULE6
		s_q.state == LSOD_ST_DET_PASS && !output_gate |=> $stable(s_q.shift))
		else $error("shift path moved during pass");
	AST_RESUME: assert property (@(posedge clk_sys) disable iff (reset) // RULE11
		resume_hit |=> s_q.state == LSOD_ST_NORMAL && s_q.hist == LSOD_HIST_CLEAR)
		else $error("resume pattern did not return to normal");
	AST_KEEP_MODE: assert property (@(posedge clk_sys) disable iff (reset) // RULE14
		!entry_hit && !resume_hit |=> detect_mode == $past(detect_mode))
		else $error("mode changed without a full pattern");

	// Pass boundaries, status keeping and the read path
	AST_SHORT_PASS: assert property (@(posedge clk_sys) disable iff (reset) // RULE8
		s_q.state == LSOD_ST_DET_PASS && output_gate && s_q.low_cnt != LSOD_LOW_MIN && !entry_hit && !resume_hit
		|=> s_q.state == LSOD_ST_DET_IDLE && s_q.status == $past(s_q.status))
		else $error("short pass changed the status");
	AST_STATUS_KEEP: assert property (@(posedge clk_sys) disable iff (reset) // RULE13
		s_q.state != LSOD_ST_DET_PASS || output_gate |=> $stable(s_q.status))
		else $error("status changed outside a low pass edge");
	AST_SHIFT_IDLE: assert property (@(posedge clk_sys) disable iff (reset) // RULE3
		s_q.state == LSOD_ST_DET_IDLE
		|=> s_q.shift[0] == $past(serial_in) && s_q.shift[LSOD_CH-1:1] == $past(s_q.shift[LSOD_CH-2:0]))
		else $error("serial data not shifted in detection mode");
	AST_OUT_BIT: assert property (@(posedge clk_sys) disable iff (reset) // RULE10
		s_q.state == LSOD_ST_DET_IDLE |=> serial_out == $past(s_q.shift[LSOD_CH-2]))
		else $error("serial output did not advance one bit");
	AST_RESTART: assert property (@(posedge clk_sys) disable iff (reset) // RULE14
		entry_hit |=> s_q.hist == LSOD_HIST_CLEAR)
		else $error("pattern window not cleared after entry");
	AST_FALL_ONLY: assert property (@(posedge clk_sys) disable iff (reset) // RULE4
		s_q.state == LSOD_ST_DET_IDLE && !(s_q.gate_prev && !output_gate) && !entry_hit && !resume_hit
		|=> s_q.state == LSOD_ST_DET_IDLE)
		else $error("pass started without a gate fall");

	// Scenarios worth seeing
	COV_ENTRY: cover property (@(posedge clk_sys) disable iff (reset) entry_hit);
	COV_PASS: cover property (@(posedge clk_sys) disable iff (reset)
		s_q.state == LSOD_ST_DET_PASS && output_gate && s_q.low_cnt == LSOD_LOW_MIN);
	COV_RESUME: cover property (@(posedge clk_sys) disable iff (reset) resume_hit && detect_mode);
	COV_FULL: cover property (@(posedge clk_sys) disable iff (reset) !latch_ready);
	COV_SHORT: cover property (@(posedge clk_sys) disable iff (reset)
		s_q.state == LSOD_ST_DET_PASS && output_gate && s_q.low_cnt != LSOD_LOW_MIN);
endmodule

// >>> logic/lsod_fifo.sv
`timescale 1ns/10ps
module lsod_fifo import lsod_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
	localparam logic [CW-1:0] CNT_ZERO = '0;
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [CW-1:0] count;
		logic full;
	} lsod_fifo_st_t;

	lsod_fifo_st_t s_q;
	lsod_fifo_st_t s_d;
	logic push;
	logic pop;

	// Handshakes against registered flags
	assign in_ready = !s_q.full;
	assign out_valid = (s_q.count != CNT_ZERO);
	assign out_data = s_q.mem[s_q.rd_ptr];
	assign push = in_valid && !s_q.full;
	assign pop = out_ready && (s_q.count != CNT_ZERO);

	// Pointer, count and storage update
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr_ptr] = in_data;
			s_d.wr_ptr = (s_q.wr_ptr == PTR_LAST) ? '0 : s_q.wr_ptr + 1'b1;
		end
		if (pop) begin
			s_d.rd_ptr = (s_q.rd_ptr == PTR_LAST) ? '0 : s_q.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			s_d.count = s_q.count + 1'b1;
		end else if (pop && !push) begin
			s_d.count = s_q.count - 1'b1;
		end
		s_d.full = (s_d.count == CNT_FULL);
	end

	// State register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// >>> logic/lsod_pkg.sv
package lsod_pkg;
	// Channel count and buffering depth
	localparam int LSOD_CH = 8;
	localparam int LSOD_FIFO_DEPTH = 8;
	// Sampled (output_gate, latch_strobe) pairs
	localparam logic [1:0] LSOD_PAIR_GATE = 2'h2;
	localparam logic [1:0] LSOD_PAIR_LOW = 2'h0;
	localparam logic [1:0] LSOD_PAIR_BOTH = 2'h3;
	// Five-pair history, oldest pair in the top bits
	localparam int LSOD_HIST_W = 10;
	localparam logic [9:0] LSOD_HIST_CLEAR = 10'h000;
	localparam logic [9:0] LSOD_ENTRY_SEQ = 10'h22E;
	localparam logic [9:0] LSOD_RESUME_SEQ = 10'h22A;
	// Low samples needed before status is kept
	localparam logic [1:0] LSOD_LOW_MIN = 2'h3;
	localparam logic [1:0] LSOD_LOW_ONE = 2'h1;
	localparam logic [1:0] LSOD_LOW_NONE = 2'h0;
	// Reset values
	localparam logic [7:0] LSOD_STATUS_RST = 8'hFF;
	localparam logic [7:0] LSOD_BYTE_ZERO = 8'h00;
	// Operating states
	typedef enum logic [1:0] {
		LSOD_ST_NORMAL,
		LSOD_ST_DET_IDLE,
		LSOD_ST_DET_PASS
	} lsod_state_t;
endpackage

// >>> tb/lsod_core_bench.sv
`timescale 1ns/10ps
module lsod_core_bench import lsod_pkg::*; ();
	logic clk_sys;
	logic reset;
	logic [7:0] channel_ok;
	logic serial_in, latch_strobe, output_gate, serial_out, detect_mode, latch_ready;
	logic [7:0] sink_channel;
	int error_cnt = 0;
	int n_tests = 0;
	// Controller stands in front of the core
	lsod_ctrl_model lsod_ctrl_model_inst (.clk_sys(clk_sys), .serial_in(serial_in),
		.latch_strobe(latch_strobe), .output_gate(output_gate));
	lsod_core lsod_core_inst (.clk_sys(clk_sys), .reset(reset), .serial_in(serial_in),
		.latch_strobe(latch_strobe), .output_gate(output_gate), .serial_out(serial_out),
		.channel_ok(channel_ok), .sink_channel(sink_channel), .detect_mode(detect_mode),
		.latch_ready(latch_ready));
	// 200 MHz clock
	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Shared comparison
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask
	// Clock out eight serial bits, first one due at the next edge
	task automatic read_out(input logic [7:0] exp);
		logic [7:0] got;
		for (int i = 7; i >= 0; i--) begin
			lsod_ctrl_model_inst.step(1'h1, 1'h0, 1'h0);
			#1;
			got[i] = serial_out;
		end
		chk(got, exp);
	endtask
	// Pattern with a data byte riding along, then mode and data checked
	task automatic t_mode(input logic [9:0] seq, input logic [7:0] d, input logic exp);
		lsod_ctrl_model_inst.pattern(seq, d[7:3]);
		for (int i = 2; i >= 0; i--) begin
			lsod_ctrl_model_inst.step(1'h1, 1'h0, d[i]);
		end
		read_out(d);
		chk({7'h00, detect_mode}, {7'h00, exp});
	endtask
	// Full pass; status captured and shifted out
	task automatic t_pass(input logic [7:0] ok);
		@(posedge clk_sys);
		channel_ok <= ok;
		lsod_ctrl_model_inst.pass(400);
		read_out(ok);
	endtask
	// Latch word through the FIFO, filled until refused
	task automatic t_fifo();
		for (int i = 7; i >= 0; i--) begin
			lsod_ctrl_model_inst.step(1'h1, 1'h0, i[0]);
		end
		repeat (9) lsod_ctrl_model_inst.step(1'h0, 1'h1, 1'h0);
		lsod_ctrl_model_inst.step(1'h0, 1'h0, 1'h0);
		#1 chk({7'h00, latch_ready}, 8'h00);
		lsod_ctrl_model_inst.step(1'h1, 1'h0, 1'h0);
		repeat (3) lsod_ctrl_model_inst.step(1'h0, 1'h0, 1'h0);
		#1 chk(sink_channel, 8'hAA);
		chk({7'h00, latch_ready}, 8'h01);
		repeat (9) lsod_ctrl_model_inst.step(1'h1, 1'h0, 1'h0);
		#1 chk({7'h00, latch_ready}, 8'h01);
	endtask
	// Main sequence
	initial begin
		reset = 1'h1;
		channel_ok = 8'hFF;
		repeat (2) @(posedge clk_sys);
		#1 chk(sink_channel, 8'h00);
		chk({5'h00, serial_out, detect_mode, latch_ready}, 8'h01);
		@(posedge clk_sys);
		reset <= 1'h0;
		t_mode(10'h22C, 8'h4B, 1'h0);
		t_mode(LSOD_ENTRY_SEQ, 8'hB5, 1'h1);
		t_pass(8'h5A);
		t_pass(8'hFF);
		t_mode(LSOD_RESUME_SEQ, 8'hC3, 1'h0);
		t_fifo();
		end_of_test();
	end
	// Hang guard, far beyond the expected run
	initial begin
		#20000;
		error_cnt++;
		end_of_test();
	end
endmodule

// >>> tb/lsod_ctrl_model.sv
`timescale 1ns/10ps
module lsod_ctrl_model (
	// Clock from the bench
	input wire logic clk_sys,
	// Controller lines
	output logic serial_in,
	output logic latch_strobe,
	output logic output_gate
);
	// Idle levels follow the pin pulls, gate up and strobe down
	initial begin
		serial_in = 1'h0;
		latch_strobe = 1'h0;
		output_gate = 1'h1;
	end
	// One pair and one data bit, launched on an edge for the next one
	task automatic step(input logic g, input logic s, input logic d);
		@(posedge clk_sys);
		output_gate <= g;
		latch_strobe <= s;
		serial_in <= d;
	endtask
	// Five pairs, oldest first, data still flowing
	task automatic pattern(input logic [9:0] seq, input logic [4:0] d);
		for (int i = 0; i < 5; i++) begin
			step(seq[9-2*i], seq[8-2*i], d[4-i]);
		end
	endtask
	// Gate low for n edges with no data, then raised before any read
	task automatic pass(input int n);
		for (int i = 0; i < n; i++) begin
			step(1'h0, 1'h0, 1'h0);
		end
		step(1'h1, 1'h0, 1'h0);
	endtask
endmodule
